// *** rtl/cap_regs_defines.vh ***
// constants for the capability register bank: offsets, field values, widths
// assumes inclusion by bare name from every design file that needs them
`ifndef CAP_REGS_DEFINES_VH
`define CAP_REGS_DEFINES_VH

// byte address width of the processor interface, A[17:1] plus an implied A0
`define ADDR_W 18
`define PIN_ADDR_W 17
`define DATA_W 32
`define HALF_W 16

// register byte offsets
`define CAP_LENGTH_ADDR 18'h00000
`define IF_VERSION_ADDR 18'h00002
`define STRUCT_PARAMS_ADDR 18'h00004
`define CAP_PARAMS_ADDR 18'h00008
// capability space spans from the base up to the operational registers
`define CAP_SPACE_LAST 18'h0001F
// base of the whole register space
`define REG_BASE_ADDR 18'h00000

// word index (byte address over four) of each 32-bit word
`define WORD_IDX_W 3
`define WORD_IDX_LSB 2
`define WORD_IDX_MSB 4
`define WORD_LENGTH_VERSION 3'h0
`define WORD_STRUCT 3'h1
`define WORD_CAPS 3'h2

// address bit that picks the upper half on a 16-bit bus
`define HALF_SEL_BIT 1

// capability length and interface version
`define CAP_LENGTH_W 8
`define CAP_LENGTH_VALUE 8'h20
`define IF_VERSION_VALUE 16'h0100
`define LENGTH_PAD 8'h00

// structural parameters fields, most significant first
`define STRUCT_RSV_HI 8'h00
`define DEBUG_PORT_NUMBER 4'h0
`define STRUCT_RSV_MID 3'h0
`define PORT_INDICATOR 1'h0
`define COMPANION_CONTROLLER_COUNT 4'h0
`define PORTS_PER_COMPANION 4'h0
`define PORT_ROUTING_RULES 1'h0
`define STRUCT_RSV_LO 2'h0
`define PORT_POWER_CONTROL 1'h1
`define DOWNSTREAM_PORT_COUNT 4'h1

// capability parameters fields, most significant first
`define CAPS_RSV_HI 16'h0000
`define EXTENDED_CAPABILITIES_POINTER 8'h00
`define ISOCHRONOUS_SCHEDULING_THRESHOLD 4'h8
`define CAPS_RSV_BIT3 1'h0
`define ASYNC_PARK_CAPABILITY 1'h1
`define PROGRAMMABLE_FRAME_LIST_FLAG 1'h1
`define CAPS_RSV_BIT0 1'h0

`define ZERO_WORD 32'h00000000
`define ZERO_HALF 16'h0000

`endif

// *** rtl/pin_sync.v ***
// two flip-flop synchroniser for a group of level inputs from the pins
// assumes each bit is a slow level; a multi-bit group is only coherent once stable
`timescale 1ns/100ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage1_reg <= RESET_VALUE;
      stage2_reg <= RESET_VALUE;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule

// *** rtl/cap_value_rom.v ***
// constant read values of the capability words, selected by word index
// assumes the caller has already checked that the address is in capability space
`timescale 1ns/100ps
`include "cap_regs_defines.vh"
module cap_value_rom (
  input wire [`WORD_IDX_W-1:0] i_word_index,
  output reg [`DATA_W-1:0] o_word
);

  always @* begin
    case (i_word_index)
      `WORD_LENGTH_VERSION: begin
        // version in the upper half, length in the lowest byte
        o_word = {`IF_VERSION_VALUE, `LENGTH_PAD, `CAP_LENGTH_VALUE};
      end
      `WORD_STRUCT: begin
        o_word = {`STRUCT_RSV_HI,
                  `DEBUG_PORT_NUMBER,
                  `STRUCT_RSV_MID,
                  `PORT_INDICATOR,
                  `COMPANION_CONTROLLER_COUNT,
                  `PORTS_PER_COMPANION,
                  `PORT_ROUTING_RULES,
                  `STRUCT_RSV_LO,
                  `PORT_POWER_CONTROL,
                  `DOWNSTREAM_PORT_COUNT};
      end
      `WORD_CAPS: begin
        o_word = {`CAPS_RSV_HI,
                  `EXTENDED_CAPABILITIES_POINTER,
                  `ISOCHRONOUS_SCHEDULING_THRESHOLD,
                  `CAPS_RSV_BIT3,
                  `ASYNC_PARK_CAPABILITY,
                  `PROGRAMMABLE_FRAME_LIST_FLAG,
                  `CAPS_RSV_BIT0};
      end
      default: begin
        // unused words of capability space read as zero
        o_word = `ZERO_WORD;
      end
    endcase
  end

endmodule

// *** rtl/usb_host_capability_registers.v ***
// capability register bank of a usb 2.0 host controller, on the processor pins
// assumes the pins come from another domain, and that another block answers
// every address above capability space and merges its data with ours
//
// Contract
// - The lowest byte of the first word reads as capability length 20h.
// - The interface version halfword reads as the BCD value 0100h.
// - Reserved structural bits 31:24, 19:17 and 6:5 read zero and are written zero.
// - The downstream port count in structural bits 3:0 reads as one port.
// - Structural bit 4 reads one, reporting port power control.
// - The port routing rules bit, structural bit 7, reads zero.
// - Companion controller count 15:12 and ports per companion 11:8 read zero.
// - The debug port number in structural bits 23:20 reads zero.
// - The port indicator bit, structural bit 16, reads zero.
// - Capability parameter bits 31:16, 3 and 0 are reserved, read zero, written zero.
// - The extended capabilities pointer in bits 15:8 reads zero, so no list exists.
// - The isochronous scheduling threshold in bits 7:4 reads as 1000 binary.
// - Capability bit 2 reads one, reporting the asynchronous park capability.
// - Capability bit 1 reads one, allowing a smaller programmed frame list.
`timescale 1ns/100ps
`include "cap_regs_defines.vh"
module usb_host_capability_registers (
  input wire i_clk,
  input wire i_reset,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [`PIN_ADDR_W-1:0] i_addr,
  input wire i_bus_width_16,
  output reg [`DATA_W-1:0] o_data,
  output reg o_data_oe_n,
  output wire o_cap_select,
  output reg o_read_done,
  output reg o_write_ignored,
  output wire [`ADDR_W-1:0] o_operational_base
);

  // one-hot access states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_READ = 4'b0010;
  localparam [3:0] ST_WRITE = 4'b0100;
  localparam [3:0] ST_RECOVER = 4'b1000;

  // true when a byte address falls inside capability space
  function in_cap_space;
    input [`ADDR_W-1:0] byte_addr;
    begin
      in_cap_space = (byte_addr <= `CAP_SPACE_LAST);
    end
  endfunction

  // word index of a byte address
  function [`WORD_IDX_W-1:0] word_index;
    input [`ADDR_W-1:0] byte_addr;
    begin
      word_index = byte_addr[`WORD_IDX_MSB:`WORD_IDX_LSB];
    end
  endfunction

  // data placed on the pins for a word, narrowed on a 16-bit bus
  function [`DATA_W-1:0] lane_value;
    input [`DATA_W-1:0] word;
    input narrow;
    input upper;
    begin
      if (!narrow) begin
        lane_value = word;
      end else if (upper) begin
        lane_value = {`ZERO_HALF, word[`DATA_W-1:`HALF_W]};
      end else begin
        lane_value = {`ZERO_HALF, word[`HALF_W-1:0]};
      end
    end
  endfunction

  wire cs_n_sync;
  wire rd_n_sync;
  wire wr_n_sync;
  wire [`PIN_ADDR_W-1:0] addr_sync;

  // strobes reset to their idle high level so no access is seen at release
  pin_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h7)
  ) strobe_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_cs_n, i_rd_n, i_wr_n}),
    .o_sync({cs_n_sync, rd_n_sync, wr_n_sync})
  );

  // the address settles before the strobes, so it is stable when sampled
  pin_sync #(
    .WIDTH(`PIN_ADDR_W),
    .RESET_VALUE(17'h00000)
  ) address_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_addr),
    .o_sync(addr_sync)
  );

  wire [`ADDR_W-1:0] byte_addr;
  wire addr_hit;
  wire read_request;
  wire write_request;

  assign byte_addr = {addr_sync, 1'b0};
  assign addr_hit = in_cap_space(byte_addr);
  assign read_request = !cs_n_sync && !rd_n_sync && addr_hit;
  assign write_request = !cs_n_sync && !wr_n_sync && addr_hit;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`ADDR_W-1:0] latched_addr_reg;
  reg [`ADDR_W-1:0] latched_addr_next;
  reg [`DATA_W-1:0] data_next;
  reg oe_n_next;
  reg read_done_next;
  reg write_ignored_next;

  wire [`DATA_W-1:0] rom_word;

  cap_value_rom value_rom (
    .i_word_index(word_index(latched_addr_next)),
    .o_word(rom_word)
  );

  // the operational registers start at base plus the constant length
  assign o_operational_base = `REG_BASE_ADDR + {{(`ADDR_W-`CAP_LENGTH_W){1'b0}},
                              `CAP_LENGTH_VALUE};

  // tells the merging logic that this bank owns the current access
  assign o_cap_select = (state_reg == ST_READ) || (state_reg == ST_WRITE);

  always @* begin
    state_next = state_reg;
    latched_addr_next = latched_addr_reg;
    data_next = o_data;
    oe_n_next = o_data_oe_n;
    read_done_next = 1'b0;
    write_ignored_next = 1'b0;
    case (state_state_sel(state_reg))
      ST_IDLE: begin
        oe_n_next = 1'b1;
        if (read_request) begin
          latched_addr_next = byte_addr;
          state_next = ST_READ;
        end else if (write_request) begin
          state_next = ST_WRITE;
        end
      end
      ST_READ: begin
        // data is held constant for the whole strobe; words never change
        data_next = lane_value(rom_word, i_bus_width_16,
                               latched_addr_reg[`HALF_SEL_BIT]);
        oe_n_next = 1'b0;
        if (cs_n_sync || rd_n_sync) begin
          oe_n_next = 1'b1;
          read_done_next = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_WRITE: begin
        // written data is dropped; nothing here holds state a write could change
        if (cs_n_sync || wr_n_sync) begin
          write_ignored_next = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // one idle cycle so the bus is released before the next access
        oe_n_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        oe_n_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  // identity mapping kept as a function so the case stays on the state itself
  function [3:0] state_state_sel;
    input [3:0] s;
    begin
      state_state_sel = s;
    end
  endfunction

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      latched_addr_reg <= `REG_BASE_ADDR;
      o_data <= `ZERO_WORD;
      o_data_oe_n <= 1'b1;
      o_read_done <= 1'b0;
      o_write_ignored <= 1'b0;
    end else begin
      state_reg <= state_next;
      latched_addr_reg <= latched_addr_next;
      o_data <= data_next;
      o_data_oe_n <= oe_n_next;
      o_read_done <= read_done_next;
      o_write_ignored <= write_ignored_next;
    end
  end

endmodule

// *** testbench/cap_regs_monitor.sv ***
// concurrent checks of the capability bank, seen from its pins
// assumes address and bus width stay steady while a read is driven
`timescale 1ns/100ps
module cap_regs_monitor (
  input wire i_clk,
  input wire i_reset,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [16:0] i_addr,
  input wire i_bus_width_16,
  input wire [31:0] o_data,
  input wire o_data_oe_n,
  input wire o_cap_select,
  input wire o_read_done,
  input wire o_write_ignored,
  input wire [17:0] o_operational_base
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire drv = !o_data_oe_n;
  wire wide = drv && !i_bus_width_16;
  wire half = drv && i_bus_width_16;
  wire [15:0] w = i_addr[16:1];
  sequence read_end_s;
    $rose(o_data_oe_n);
  endsequence
  sequence pulse_s(s);
    s ##1 !s;
  endsequence
  op_base_a:
    assert property (o_operational_base == 18'h00020) else $error("operational base wrong");
  len_version_a:
    assert property (wide && w == 16'h0000 |-> o_data == 32'h01000020) else $error("word 0 wrong");
  struct_word_a:
    assert property (wide && w == 16'h0001 |-> o_data == 32'h00000011) else $error("word 1 wrong");
  caps_word_a:
    assert property (wide && w == 16'h0002 |-> o_data == 32'h00000086) else $error("word 2 wrong");
  spare_word_a:
    assert property (wide && w > 16'h0002 |-> o_data == 32'h00000000)
      else $error("spare not zero");
  half_pick_a:
    assert property (half && w == 16'h0000 |-> o_data == (i_addr[0] ? 32'h00000100 : 32'h00000020))
      else $error("halfword wrong");
  space_only_a:
    assert property (drv |-> i_addr <= 17'h0000F && o_cap_select)
      else $error("drive outside space");
  read_done_a:
    assert property (read_end_s |-> pulse_s(o_read_done)) else $error("read end pulse wrong");
  write_quiet_a:
    assert property (o_write_ignored |-> o_data_oe_n && $stable(o_data) ##1 !o_write_ignored)
      else $error("write disturbed bank");
  pulse_owner_a:
    assert property ((o_read_done || o_write_ignored) |-> $past(o_cap_select) && !o_cap_select)
      else $error("pulse without access");
endmodule
bind usb_host_capability_registers cap_regs_monitor u_mon (.i_clk(i_clk), .i_reset(i_reset),
  .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr),
  .i_bus_width_16(i_bus_width_16), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
  .o_cap_select(o_cap_select), .o_read_done(o_read_done), .o_write_ignored(o_write_ignored),
  .o_operational_base(o_operational_base));

// *** testbench/usb_host_capability_registers_tb.sv ***
// self-checking bench of the capability bank over its processor pins
// assumes pins are seen two edges late and a strobe stays low nine cycles
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module usb_host_capability_registers_tb;
  logic i_clk, i_reset, i_cs_n, i_rd_n, i_wr_n, i_bus_width_16;
  logic [16:0] i_addr;
  wire [31:0] o_data;
  wire o_data_oe_n, o_cap_select, o_read_done, o_write_ignored;
  wire [17:0] o_operational_base;
  int n_mismatch = 0;
  int total_checks = 0;
  int k;
  logic [16:0] tbl [7] = '{17'h0, 17'h1, 17'h2, 17'h3, 17'h4, 17'hF, 17'h10};
  usb_host_capability_registers dut (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
    .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr), .i_bus_width_16(i_bus_width_16),
    .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_cap_select(o_cap_select),
    .o_read_done(o_read_done), .o_write_ignored(o_write_ignored),
    .o_operational_base(o_operational_base));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  function automatic logic [31:0] exp_val(input logic [16:0] a, input logic bw);
    logic [31:0] v;
    case (a[16:1])
      16'h0000: v = 32'h01000020;
      16'h0001: v = 32'h00000011;
      16'h0002: v = 32'h00000086;
      default: v = 32'h00000000;
    endcase
    if (bw) v = a[0] ? {16'h0000, v[31:16]} : {16'h0000, v[15:0]};
    return v;
  endfunction
  // one whole pin cycle; address held until the next access starts
  task automatic acc(input logic wr, input logic [16:0] a, input logic bw);
    int i;
    logic [31:0] d0;
    logic [3:0] p;
    logic in_sp;
    in_sp = (a <= 17'h0000F);
    d0 = o_data;
    p = 4'h0;
    @(posedge i_clk);
    i_bus_width_16 <= bw;
    i_addr <= a;
    i_cs_n <= 1'b0;
    if (wr) i_wr_n <= 1'b0;
    else i_rd_n <= 1'b0;
    for (i = 0; i < 8; i++) @(posedge i_clk);
    #1;
    if (!wr && in_sp) `CHK(o_data, exp_val(a, bw))
    `CHK(o_data_oe_n, !(!wr && in_sp))
    `CHK(o_cap_select, in_sp)
    @(posedge i_clk);
    i_cs_n <= 1'b1;
    i_rd_n <= 1'b1;
    i_wr_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge i_clk);
      #1;
      p = p + {3'h0, o_read_done} + {2'h0, o_write_ignored, 1'b0};
    end
    `CHK(p, in_sp ? (wr ? 4'h2 : 4'h1) : 4'h0)
    `CHK(o_data_oe_n, 1'b1)
    `CHK(o_cap_select, 1'b0)
    if (wr) `CHK(o_data, d0)
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #60000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    i_reset = 1'b1;
    i_cs_n = 1'b1;
    i_rd_n = 1'b1;
    i_wr_n = 1'b1;
    i_addr = 17'h00000;
    i_bus_width_16 = 1'b0;
    void'($urandom(34385));
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    for (k = 0; k < 14; k++) acc(1'b0, tbl[k % 7], k / 7);
    // no data pins reach the bank, so a write carries no data to any bit, reserved or not
    for (k = 0; k < 5; k++) begin
      acc(1'b1, tbl[k], 1'b0);
      acc(1'b0, tbl[k], 1'b0);
    end
    for (k = 0; k < 40; k++)
      acc($urandom % 2, ($urandom % 4 == 0) ? 17'($urandom) : 17'($urandom % 32'h14),
          $urandom % 2);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_data_oe_n, 1'b1)
    `CHK(o_data, 32'h00000000)
    `CHK(o_operational_base, 18'h00020)
    `CHK(o_cap_select, 1'b0)
    @(posedge i_clk);
    i_reset <= 1'b0;
    acc(1'b0, 17'h00002, 1'b0);
    // data stays on the pins after the read, so the flag can be looked at here
    acc(1'b0, 17'h00004, 1'b0);
    `CHK(o_data[1], 1'b1)
    wrap_up();
  end
endmodule
